//--- core/sfc_pkg.sv
// constants, opcodes, formats and states for the serial flash front end
// assumes a 20 MHz system clock that samples the serial pins
//
// Notes on behaviour
// - power-up or reset defaults to mode 3
// - data output stays tri-stated until driving data
// - instruction starts only after a select fall
// - each select fall samples clock idle level
// - reset disables all operations and commands
// - no program or erase before 20 ms
// - after power-up the device sits in standby
// - page-and-byte opcodes: 3 x, 12 page, 9 byte
// - buffer opcodes: 15 x bits, 9 byte bits
// - dummy bytes: 4 for D2/E8, 1 for D4/D6
// - page-only opcodes; 7C keeps top page bits
// - page field 11..0, byte field 8..0
package sfc_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned SEL_DELAY_US = 70;
    localparam int unsigned SEL_DELAY_CYC =
        (SEL_DELAY_US * (CLK_HZ / 1_000_000));
    localparam int unsigned WRITE_DELAY_MS = 20;
    localparam int unsigned WRITE_DELAY_CYC =
        WRITE_DELAY_MS * (CLK_HZ / 1000);
    // field layout of the three address bytes
    localparam int unsigned OPC_W = 8;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned PAGE_W = 12;
    localparam int unsigned BYTE_W = 9;
    localparam int unsigned PAGE_LSB = 9;
    localparam int unsigned PAGE_MSB = 20;
    localparam int unsigned PAGE3_LSB = 18;
    localparam logic [5:0] OPC_LAST = 6'h07;
    localparam logic [5:0] ADDR_LAST = 6'h17;
    // reset values
    localparam logic MODE3_RST = 1'b1;
    // opcodes carrying page and byte fields
    localparam logic [7:0] OP_PB_A = 8'h82;
    localparam logic [7:0] OP_PB_B = 8'h85;
    localparam logic [7:0] OP_PB_RD4 = 8'hD2;
    localparam logic [7:0] OP_PB_RD4B = 8'hE8;
    // buffer-only opcodes
    localparam logic [7:0] OP_BF_W1 = 8'h84;
    localparam logic [7:0] OP_BF_W2 = 8'h87;
    localparam logic [7:0] OP_BF_R1 = 8'hD1;
    localparam logic [7:0] OP_BF_R2 = 8'hD3;
    localparam logic [7:0] OP_BF_RD1 = 8'hD4;
    localparam logic [7:0] OP_BF_RD1B = 8'hD6;
    // page-only opcodes
    localparam logic [7:0] OP_PG_A = 8'h81;
    localparam logic [7:0] OP_PG_B = 8'h83;
    localparam logic [7:0] OP_PG_C = 8'h86;
    localparam logic [7:0] OP_PG_D = 8'h88;
    localparam logic [7:0] OP_PG_E = 8'h89;
    localparam logic [7:0] OP_PG3 = 8'h7C;
    // dummy byte counts
    localparam logic [2:0] DUMMY_FOUR = 3'h4;
    localparam logic [2:0] DUMMY_ONE = 3'h1;
    localparam logic [2:0] DUMMY_NONE = 3'h0;
    // address format of an opcode
    typedef enum logic [2:0] {
        FMT_NONE, FMT_PAGE_BYTE, FMT_BUF, FMT_PAGE, FMT_PAGE3
    } sfc_fmt_t;
    // frame states
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_SKIP
    } sfc_state_t;
endpackage : sfc_pkg

//--- core/sfc_pin_sync.sv
// three-flop synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module sfc_pin_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic lvl,
    output logic rise,
    output logic fall
);
    logic s1; // first stage, read by s2 only
    logic s2;
    logic s3;
    // sampling chain and filtered level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            lvl <= RST_VAL;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                lvl <= s3;
            end
        end
    end
    // edges seen in the cycle the level flips
    assign rise = (s2 == s3) && s3 && !lvl;
    assign fall = (s2 == s3) && !s3 && lvl;
endmodule : sfc_pin_sync

//--- core/sfc_op_decode.sv
// opcode classifier: address format, dummy bytes, read and write kind
// assumes a complete opcode byte at its input
`timescale 1ns/1ps
module sfc_op_decode
    import sfc_pkg::*;
(
    input wire logic [7:0] opc,
    output sfc_pkg::sfc_fmt_t fmt,
    output logic [2:0] dummies,
    output logic is_read,
    output logic is_write
);
    // address format per opcode
    function automatic sfc_fmt_t fmt_of(input logic [7:0] o);
        case (o)
            OP_PB_A, OP_PB_B, OP_PB_RD4, OP_PB_RD4B: fmt_of = FMT_PAGE_BYTE;
            OP_BF_W1, OP_BF_W2, OP_BF_R1, OP_BF_R2,
            OP_BF_RD1, OP_BF_RD1B: fmt_of = FMT_BUF;
            OP_PG_A, OP_PG_B, OP_PG_C, OP_PG_D, OP_PG_E: fmt_of = FMT_PAGE;
            OP_PG3: fmt_of = FMT_PAGE3;
            default: fmt_of = FMT_NONE;
        endcase
    endfunction : fmt_of
    assign fmt = fmt_of(opc);
    // extra don't-care bytes before returned data
    assign dummies = (opc == OP_PB_RD4 || opc == OP_PB_RD4B) ? DUMMY_FOUR :
                     (opc == OP_BF_RD1 || opc == OP_BF_RD1B) ? DUMMY_ONE :
                     DUMMY_NONE;
    // opcodes that return data
    assign is_read = (opc == OP_PB_RD4) || (opc == OP_PB_RD4B) ||
                     (opc == OP_BF_RD1) || (opc == OP_BF_RD1B) ||
                     (opc == OP_BF_R1) || (opc == OP_BF_R2);
    // opcodes that program or erase the array
    assign is_write = (opc == OP_PB_A) || (opc == OP_PB_B) ||
                      (opc == OP_PG_B) || (opc == OP_PG_C) ||
                      (opc == OP_PG_D) || (opc == OP_PG_E) ||
                      (opc == OP_PG_A) || (opc == OP_PG3);
endmodule : sfc_op_decode

//--- core/sfc_front.sv
// serial flash front end: power-up state, mode detect, opcode and
// address framing, dummy bytes and read data shifting
// assumes rst is the power-on reset and pins are asynchronous
`timescale 1ns/1ps
module sfc_front
    import sfc_pkg::*;
#(
    parameter int unsigned WRITE_DELAY_CYCLES = sfc_pkg::WRITE_DELAY_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic si_pin,
    input wire logic [7:0] rd_byte,
    output logic rd_take,
    output logic so_out,
    output logic so_oe_n,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [sfc_pkg::PAGE_W-1:0] cmd_page,
    output logic [sfc_pkg::BYTE_W-1:0] cmd_byte,
    output logic cmd_write,
    output logic spi_mode3,
    output logic write_ready,
    output logic standby
);
    import sfc_pkg::*;
    localparam int WR_W = $clog2(WRITE_DELAY_CYCLES + 1);

    // synchronised pins
    logic cs_lvl, cs_rise, cs_fall;
    logic sck_lvl, sck_rise, sck_fall;
    logic si_lvl;

    // frame state
    sfc_state_t state; // current frame state
    sfc_state_t next_state; // state for the next cycle
    logic [5:0] bit_cnt; // bits in the current phase
    logic [7:0] opc_sh; // opcode shifter
    logic [ADDR_W-1:0] adr_sh; // address shifter
    logic [5:0] dummy_last; // last dummy bit index
    logic [7:0] tx_sh; // read data shifter
    logic [2:0] tx_cnt; // bit slot of read data
    logic [WR_W-1:0] wr_cnt; // power-up write delay counter

    // decoder outputs
    sfc_fmt_t fmt;
    logic [2:0] dummies;
    logic is_read, is_write;

    sfc_pin_sync #(.RST_VAL(1'b1)) u_cs (
        .clk(clk), .rst(rst), .pin(cs_n_pin),
        .lvl(cs_lvl), .rise(cs_rise), .fall(cs_fall)
    );
    sfc_pin_sync #(.RST_VAL(1'b1)) u_sck (
        .clk(clk), .rst(rst), .pin(sck_pin),
        .lvl(sck_lvl), .rise(sck_rise), .fall(sck_fall)
    );
    sfc_pin_sync #(.RST_VAL(1'b0)) u_si (
        .clk(clk), .rst(rst), .pin(si_pin),
        .lvl(si_lvl), .rise(), .fall()
    );

    // shift values, msb first
    wire [7:0] opc_next = {opc_sh[6:0], si_lvl};
    wire [ADDR_W-1:0] addr_next = {adr_sh[ADDR_W-2:0], si_lvl};
    // decode the opcode as it completes, then hold it
    wire [7:0] dec_opc = (state == ST_OPC) ? opc_next : opc_sh;

    sfc_op_decode u_dec (
        .opc(dec_opc),
        .fmt(fmt),
        .dummies(dummies),
        .is_read(is_read),
        .is_write(is_write)
    );

    // phase completion strobes
    wire opc_done = (state == ST_OPC) && sck_rise && (bit_cnt == OPC_LAST);
    wire addr_done = (state == ST_ADDR) && sck_rise &&
                     (bit_cnt == ADDR_LAST);
    wire dummy_done = (state == ST_DUMMY) && sck_rise &&
                      (bit_cnt == dummy_last);
    // program or erase refused during power-up delay
    wire wr_block = is_write && !write_ready;
    wire no_addr = (fmt == FMT_NONE);
    wire issue = (opc_done && no_addr) || (addr_done && !wr_block);
    wire [5:0] next_dummy_last = 6'({dummies, 3'h0} - 6'h01);

    // field split of the completed address
    wire [PAGE_W-1:0] f_page = addr_next[PAGE_MSB:PAGE_LSB];
    wire [BYTE_W-1:0] f_byte = addr_next[BYTE_W-1:0];
    wire [PAGE_W-1:0] f_page3 =
        {addr_next[PAGE_MSB:PAGE3_LSB], 9'h000};
    wire [PAGE_W-1:0] next_page =
        (fmt == FMT_PAGE_BYTE || fmt == FMT_PAGE) ? f_page :
        (fmt == FMT_PAGE3) ? f_page3 : 12'h000;
    wire [BYTE_W-1:0] next_byte =
        (fmt == FMT_PAGE_BYTE || fmt == FMT_BUF) ? f_byte :
        9'h000;

    // frame sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cs_fall) begin
                    next_state = ST_OPC;
                end
            end
            ST_OPC: begin
                if (opc_done) begin
                    next_state = no_addr ? ST_SKIP : ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (addr_done) begin
                    if (wr_block) begin
                        next_state = ST_SKIP;
                    end else if (dummies != DUMMY_NONE) begin
                        next_state = ST_DUMMY;
                    end else if (is_read) begin
                        next_state = ST_DATA;
                    end else begin
                        next_state = ST_SKIP;
                    end
                end
            end
            ST_DUMMY: begin
                if (dummy_done) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: next_state = ST_DATA;
            ST_SKIP: next_state = ST_SKIP;
            default: next_state = ST_IDLE;
        endcase
        if (cs_rise) begin
            next_state = ST_IDLE;
        end
    end

    // state and bit counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            bit_cnt <= 6'h00;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                bit_cnt <= 6'h00;
            end else if (sck_rise) begin
                bit_cnt <= bit_cnt + 6'h01;
            end
        end
    end

    // input shifters, sampled on rising serial clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opc_sh <= 8'h00;
            adr_sh <= 24'h000000;
            dummy_last <= 6'h00;
        end else if (sck_rise) begin
            if (state == ST_OPC) begin
                opc_sh <= opc_next;
            end
            if (state == ST_ADDR) begin
                adr_sh <= addr_next;
                dummy_last <= next_dummy_last;
            end
        end
    end

    // command presentation
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_valid <= 1'b0;
            cmd_opcode <= 8'h00;
            cmd_page <= 12'h000;
            cmd_byte <= 9'h000;
            cmd_write <= 1'b0;
        end else begin
            cmd_valid <= issue;
            if (issue) begin
                cmd_opcode <= dec_opc;
                cmd_page <= no_addr ? 12'h000 : next_page;
                cmd_byte <= no_addr ? 9'h000 : next_byte;
                cmd_write <= is_write;
            end
        end
    end

    // clock idle level picks the mode at each select fall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spi_mode3 <= MODE3_RST;
        end else if (state == ST_IDLE && cs_fall) begin
            spi_mode3 <= sck_lvl;
        end
    end

    // read data out, changed on falling serial clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            so_out <= 1'b0;
            so_oe_n <= 1'b1;
            tx_sh <= 8'h00;
            tx_cnt <= 3'h0;
            rd_take <= 1'b0;
        end else begin
            rd_take <= 1'b0;
            if (next_state != ST_DATA) begin
                so_oe_n <= 1'b1;
                tx_cnt <= 3'h0;
            end else if (state == ST_DATA && sck_fall) begin
                so_oe_n <= 1'b0;
                tx_cnt <= tx_cnt + 3'h1;
                if (tx_cnt == 3'h0) begin
                    so_out <= rd_byte[7];
                    tx_sh <= {rd_byte[6:0], 1'b0};
                    rd_take <= 1'b1;
                end else begin
                    so_out <= tx_sh[7];
                    tx_sh <= {tx_sh[6:0], 1'b0};
                end
            end
        end
    end

    // power-up write delay and standby flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_cnt <= '0;
            write_ready <= 1'b0;
            standby <= 1'b1;
        end else begin
            standby <= (next_state == ST_IDLE);
            if (wr_cnt != WR_W'(WRITE_DELAY_CYCLES)) begin
                wr_cnt <= wr_cnt + WR_W'(1);
            end
            write_ready <= (wr_cnt == WR_W'(WRITE_DELAY_CYCLES));
        end
    end

    // checks
    mode_after_reset_a: assert property (
        @(posedge clk) disable iff (rst) $past(rst) |-> spi_mode3)
        else $error("mode 3 not set after reset");
    so_idle_hiz_a: assert property (
        @(posedge clk) disable iff (rst)
        (state == ST_IDLE || state == ST_OPC) |-> so_oe_n)
        else $error("output driven outside data phase");
    start_needs_fall_a: assert property (
        @(posedge clk) disable iff (rst)
        (state == ST_IDLE && !cs_fall) |=> state == ST_IDLE)
        else $error("frame started without select fall");
    mode_sample_a: assert property (
        @(posedge clk) disable iff (rst)
        (state == ST_IDLE && cs_fall) |=>
        spi_mode3 == $past(sck_lvl))
        else $error("mode not taken from clock idle level");
    reset_quiet_a: assert property (
        @(posedge clk) disable iff (rst)
        $past(rst) |-> standby && !cmd_valid && !rd_take)
        else $error("activity right after reset");
    write_block_a: assert property (
        @(posedge clk) disable iff (rst)
        (cmd_valid && cmd_write) |-> write_ready)
        else $error("write issued before power-up delay");
    write_delay_a: assert property (
        @(posedge clk) disable iff (rst)
        (wr_cnt < WR_W'(WRITE_DELAY_CYCLES)) |-> !write_ready)
        else $error("write allowed too early");
    standby_end_a: assert property (
        @(posedge clk) disable iff (rst)
        cs_rise |=> standby ##1 standby || cs_fall || !cs_lvl)
        else $error("no standby after deselect");
    page_field_a: assert property (
        @(posedge clk) disable iff (rst)
        (addr_done && fmt == FMT_PAGE_BYTE && !wr_block) |=>
        cmd_valid && cmd_page == $past(addr_next[20:9]) &&
        cmd_byte == $past(addr_next[8:0]))
        else $error("page and byte fields misplaced");
    buf_field_a: assert property (
        @(posedge clk) disable iff (rst)
        (addr_done && fmt == FMT_BUF) |=>
        cmd_page == 12'h000 && cmd_byte == $past(addr_next[8:0]))
        else $error("buffer byte field misplaced");
    dummy_count_a: assert property (
        @(posedge clk) disable iff (rst)
        (addr_done && dummies == DUMMY_ONE && !cs_rise) |=>
        state == ST_DUMMY && dummy_last == 6'h07)
        else $error("wrong dummy length");
    page_only_a: assert property (
        @(posedge clk) disable iff (rst)
        (addr_done && fmt == FMT_PAGE3 && !wr_block) |=>
        cmd_byte == 9'h000 && cmd_page[8:0] == 9'h000)
        else $error("page-only fields not cleared");
    read_cov_c: cover property (
        @(posedge clk) disable iff (rst) rd_take && !so_oe_n);
    mode0_cov_c: cover property (
        @(posedge clk) disable iff (rst) cmd_valid && !spi_mode3);
    block_cov_c: cover property (
        @(posedge clk) disable iff (rst) addr_done && wr_block);
endmodule : sfc_front

//--- sim/sfc_host_model.sv
// host side model: drives select, serial clock and serial data in
// assumes the bench clock paces it; tasks are called from the bench
`timescale 1ns/1ps
module sfc_host_model (
    input wire logic clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so
);
    // idle: deselected, clock parked high
    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
        si = 1'b0;
    end

    // wait a number of system clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // park clock at its idle level, then drop select
    task automatic begin_frame(input logic idle_hi);
        sck <= idle_hi;
        tick(6);
        cs_n <= 1'b0;
        tick(6);
    endtask : begin_frame

    // one byte msb first; data set on fall, read before the next fall
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck <= 1'b0;
            si <= tx[i];
            tick(4);
            sck <= 1'b1;
            tick(4);
            rx[i] = so;
        end
    endtask : xfer

    // serial clock edges with select high; the device must ignore them
    task automatic stray_clock(input int n);
        repeat (n) begin
            sck <= ~sck;
            tick(5);
        end
    endtask : stray_clock

    // return clock to idle, raise select, scramble the released data line
    task automatic end_frame(input logic idle_hi);
        sck <= idle_hi;
        tick(4);
        cs_n <= 1'b1;
        si <= ~si;
        tick(8);
    endtask : end_frame
endmodule : sfc_host_model

//--- sim/sfc_front_tb_top.sv
// self-checking bench for the serial flash front end
// assumes sfc_front, sfc_pkg and the host model are compiled before it
`timescale 1ns/1ps
module sfc_front_tb_top;
    import sfc_pkg::*;
    localparam int unsigned WDLY = 2000; // shortened write delay
    localparam logic [23:0] ADR = 24'hB5C3E7; // reserved bits set
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, sck, si, so_line;
    logic [7:0] rd_byte = 8'hA5;
    logic rd_take, so_out, so_oe_n, cmd_valid, cmd_write;
    logic spi_mode3, write_ready, standby;
    logic [7:0] cmd_opcode;
    logic [PAGE_W-1:0] cmd_page;
    logic [BYTE_W-1:0] cmd_byte;
    int errors = 0;
    int cmp_count = 0;
    int cv_cnt = 0; // framed commands seen
    int since_rst = 0; // cycles since reset release
    logic [7:0] r; // scratch receive byte

    always #25 clk = ~clk;
    // released output line sits at its pull-up level
    assign so_line = so_oe_n ? 1'b1 : so_out;

    sfc_front #(.WRITE_DELAY_CYCLES(WDLY)) dut_u (
        .clk(clk), .rst(rst), .cs_n_pin(cs_n), .sck_pin(sck),
        .si_pin(si), .rd_byte(rd_byte), .rd_take(rd_take),
        .so_out(so_out), .so_oe_n(so_oe_n), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_page(cmd_page),
        .cmd_byte(cmd_byte), .cmd_write(cmd_write),
        .spi_mode3(spi_mode3), .write_ready(write_ready),
        .standby(standby)
    );
    sfc_host_model host_u (
        .clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_line)
    );

    // count pulses, step the read source each time a byte is taken
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) cv_cnt <= cv_cnt + 1;
        if (rd_take === 1'b1) rd_byte <= rd_byte + 8'h11;
        since_rst <= rst ? 0 : since_rst + 1;
    end

    // compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check

    // verdict and end of run
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    // opcode byte and three address bytes
    task automatic send_cmd(input logic [7:0] op, input logic m3);
        host_u.begin_frame(m3);
        host_u.xfer(op, r);
        host_u.xfer(ADR[23:16], r);
        host_u.xfer(ADR[15:8], r);
        host_u.xfer(ADR[7:0], r);
        host_u.end_frame(m3);
    endtask : send_cmd

    // reset state of mode, output enable, standby, write ready and command valid
    task automatic test_reset_state;
        check(32'(spi_mode3), 1, "mode after reset");
        check(32'(so_oe_n), 1, "output released");
        check(32'(standby), 1, "standby");
        check(32'(write_ready), 0, "write ready");
        check(32'(cmd_valid), 0, "no command");
        $display("test reset state done");
    endtask : test_reset_state

    // program opcode before the write delay is refused
    task automatic test_early_write;
        int n0;
        host_u.tick(1400);
        n0 = cv_cnt;
        send_cmd(8'h82, 1'b1);
        check(32'(cv_cnt - n0), 0, "early write framed");
        while (write_ready !== 1'b1 && since_rst < 3 * WDLY) host_u.tick(1);
        check(32'(since_rst + 2 >= WDLY && since_rst <= WDLY + 4), 1,
              "write delay");
        $display("test early write done");
    endtask : test_early_write

    // every addressed opcode, alternating mode 0 and mode 3
    task automatic test_formats;
        logic [7:0] ops [16] = '{8'h82, 8'h85, 8'hD2, 8'hE8, 8'h84, 8'h87,
            8'hD1, 8'hD3, 8'hD4, 8'hD6, 8'h81, 8'h83, 8'h86, 8'h88,
            8'h89, 8'h7C};
        logic [11:0] pg;
        logic [8:0] by;
        logic wr;
        int n0;
        for (int i = 0; i < 16; i++) begin
            n0 = cv_cnt;
            send_cmd(ops[i], i[0]);
            // expected fields by opcode class
            pg = (i < 4 || i >= 10) ? ADR[20:9] : 12'h000;
            by = (i < 10) ? ADR[8:0] : 9'h000;
            if (i == 15) pg = {ADR[20:18], 9'h000};
            wr = (i < 2 || i >= 10);
            check(32'(spi_mode3), 32'(i[0]), "mode select");
            check(32'(cv_cnt - n0), 1, "one command");
            check(32'(cmd_opcode), 32'(ops[i]), "opcode");
            check(32'(cmd_page), 32'(pg), "page field");
            check(32'(cmd_byte), 32'(by), "byte field");
            check(32'(cmd_write), 32'(wr), "write class");
        end
        $display("test formats done");
    endtask : test_formats

    // read after nd dummy bytes (none for D1), two data bytes returned
    task automatic test_read(input logic [7:0] op, input int nd,
                             input logic m3);
        logic [7:0] e0, b0, b1;
        e0 = rd_byte;
        host_u.begin_frame(m3);
        host_u.xfer(op, r);
        check(32'(standby), 0, "busy in frame");
        host_u.xfer(ADR[23:16], r);
        host_u.xfer(ADR[15:8], r);
        host_u.xfer(ADR[7:0], r);
        repeat (nd) host_u.xfer(8'h00, r);
        host_u.xfer(8'h00, b0);
        host_u.xfer(8'h00, b1);
        check(32'(so_oe_n), 0, "driving data");
        check(32'(b0), 32'(e0), "first data");
        check(32'(b1), 32'(8'(e0 + 8'h11)), "second data");
        host_u.end_frame(m3);
        check(32'(so_oe_n), 1, "released after frame");
        check(32'(standby), 1, "standby after frame");
        $display("test read %h done", op);
    endtask : test_read

    // cut frame and clock edges while deselected frame nothing
    task automatic test_idle_sck;
        int n0;
        n0 = cv_cnt;
        host_u.begin_frame(1'b0);
        host_u.xfer(8'h85, r);
        host_u.xfer(8'h12, r);
        host_u.end_frame(1'b0);
        host_u.stray_clock(8);
        check(32'(cv_cnt - n0), 0, "stray command");
        check(32'(standby), 1, "stays standby");
        $display("test idle clock done");
    endtask : test_idle_sck

    // opcode without address fields frames at once, fields zero
    task automatic test_no_addr;
        int n0;
        n0 = cv_cnt;
        host_u.begin_frame(1'b1);
        host_u.xfer(8'h9F, r);
        host_u.xfer(8'h00, r);
        host_u.end_frame(1'b1);
        check(32'(cv_cnt - n0), 1, "bare opcode framed");
        check(32'(cmd_opcode), 32'h9F, "bare opcode");
        check(32'(cmd_page), 0, "bare page");
        check(32'(cmd_byte), 0, "bare byte");
        check(32'(cmd_write), 0, "bare write class");
        $display("test bare opcode done");
    endtask : test_no_addr

    // reset in mid-run restores mode 3 and clears write ready
    task automatic test_second_reset;
        send_cmd(8'hD1, 1'b0);
        check(32'(spi_mode3), 0, "mode 0 seen");
        rst <= 1'b1;
        host_u.tick(20);
        check(32'(spi_mode3), 1, "mode in reset");
        check(32'(write_ready), 0, "ready in reset");
        check(32'(so_oe_n), 1, "released in reset");
        rst <= 1'b0;
        host_u.tick(2);
        check(32'(standby), 1, "standby after reset");
        $display("test second reset done");
    endtask : test_second_reset

    // main sequence
    initial begin
        host_u.tick(20);
        rst <= 1'b0;
        host_u.tick(2);
        test_reset_state();
        test_early_write();
        test_formats();
        test_read(8'hD4, 1, 1'b0);
        test_read(8'hD6, 1, 1'b1);
        test_read(8'hD2, 4, 1'b1);
        test_read(8'hE8, 4, 1'b0);
        test_read(8'hD1, 0, 1'b0);
        test_idle_sck();
        test_no_addr();
        test_second_reset();
        end_sim();
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("BAD t=%0t watchdog expired", $time);
        end_sim();
    end
endmodule : sfc_front_tb_top
